/* shared/cwo_pkg.sv */
package cwo_pkg;
    // ****************************************************************
    // Configuration word addresses
    // ****************************************************************
    localparam logic [21:0] ADDR_CLOCK_LOCK = 22'h300001;
    localparam logic [21:0] ADDR_RESET_POWER = 22'h300002;
    localparam logic [21:0] ADDR_SYSTEM = 22'h300003;
    localparam logic [21:0] ADDR_WDT_MODE_PERIOD = 22'h300004;
    localparam logic [21:0] ADDR_WDT_CLOCK_WINDOW = 22'h300005;
    localparam logic [21:0] ADDR_MEM_PARTITION = 22'h300006;
    localparam logic [21:0] ADDR_WRITE_PROTECT = 22'h300007;
    localparam int NUM_WORDS = 7;

    // ****************************************************************
    // Erased values and writable masks
    // ****************************************************************
    localparam logic [7:0] ERASED_WORD = 8'hFF;
    localparam logic [7:0] RESET_POWER_RESET = 8'h7F;
    localparam logic [7:0] MASK_CLOCK_LOCK = 8'h2B;
    localparam logic [7:0] MASK_RESET_POWER = 8'hFF;
    localparam logic [7:0] MASK_SYSTEM = 8'hBF;
    localparam logic [7:0] MASK_WDT_MODE_PERIOD = 8'h7F;
    localparam logic [7:0] MASK_WDT_CLOCK_WINDOW = 8'h3F;
    localparam logic [7:0] MASK_MEM_PARTITION = 8'h3F;
    localparam logic [7:0] MASK_WRITE_PROTECT = 8'h8F;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int POS_PRIO_ONCE = 1;
    localparam int POS_CLKOUT_N = 0;
    localparam int POS_BOR_EN = 6;
    localparam int POS_LP_BOR_N = 5;
    localparam int POS_IVT_ONCE = 4;
    localparam int POS_MVEC = 3;
    localparam int POS_PWRT = 1;
    localparam int POS_MCLR_EN = 0;
    localparam int POS_XISA_DIS = 7;
    localparam int POS_LV_PROG = 5;
    localparam int POS_STACK_RST = 4;
    localparam int POS_PPS_ONCE = 3;
    localparam int POS_ZC_DIS = 2;
    localparam int POS_BOR_V = 0;
    localparam int POS_WDT_MODE = 5;
    localparam int POS_WDT_PER = 0;
    localparam int POS_WDT_CLK = 3;
    localparam int POS_WDT_WIN = 0;
    localparam int POS_DEBUG_N = 5;
    localparam int POS_SAF_N = 4;
    localparam int POS_BB_N = 3;
    localparam int POS_BB_SIZE = 0;
    localparam int POS_WP_APP = 7;
    localparam int POS_WP_SAF = 3;
    localparam int POS_WP_EE = 2;
    localparam int POS_WP_CFG = 1;
    localparam int POS_WP_BOOT = 0;

    // ****************************************************************
    // Decoded constants
    // ****************************************************************
    localparam logic [2:0] XOSC_HS = 3'h2;
    localparam logic [2:0] XOSC_XT = 3'h1;
    localparam logic [2:0] XOSC_LP = 3'h0;
    localparam logic [4:0] WDT_PER_SOFT = 5'h1F;
    localparam logic [4:0] WDT_PER_SOFT_LOAD = 5'h0B;
    localparam logic [4:0] WDT_PER_MAX = 5'h12;
    localparam logic [2:0] WDT_CLK_SOFT = 3'h7;
    localparam logic [2:0] WDT_CLK_SEC_OSC = 3'h2;
    localparam logic [2:0] WDT_WIN_SOFT_MIN = 3'h6;
    localparam logic [2:0] BB_SIZE_RESERVED = 3'h0;
    localparam logic [2:0] BB_SIZE_SMALLEST = 3'h7;
    localparam int BB_SMALLEST_WORDS = 512;
    localparam int PFM_WORDS = 65536;
    localparam int PWRT_64MS = 64;
    localparam int PWRT_16MS = 16;
    localparam int PWRT_1MS = 1;
    localparam int CLK_HZ = 50000000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam logic [15:0] FOSC4_DIV = 16'h0002;

    typedef enum logic [1:0] {
        CWO_BOR_OFF = 2'h0,
        CWO_BOR_SOFT = 2'h1,
        CWO_BOR_AWAKE = 2'h2,
        CWO_BOR_ALWAYS = 2'h3
    } cwo_mode_e;

    typedef enum logic [3:0] {
        CWO_LOCK_OPEN = 4'h1,
        CWO_LOCK_SET = 4'h2,
        CWO_LOCK_CLEARED = 4'h4,
        CWO_LOCK_FROZEN = 4'h8
    } cwo_lock_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [21:0] addr;
        logic [7:0] data;
        logic lv_mode;
        logic bulk_erase;
    } cwo_prog_s;

    typedef struct packed {
        cwo_mode_e bor_mode;
        logic lp_bor_on;
        logic [1:0] bor_level;
        logic mvec_on;
        logic [1:0] pwrt_sel;
        logic [31:0] pwrt_cycles;
        logic mclr_on;
        logic xisa_on;
        logic stack_reset_on;
        logic zc_forced_on;
        logic zc_soft_ok;
        cwo_mode_e wdt_mode;
        logic [4:0] wdt_prescale;
        logic wdt_prescale_soft;
        logic [2:0] wdt_clock;
        logic wdt_clock_soft;
        logic [2:0] wdt_window;
        logic wdt_window_soft;
        logic wdt_keyed;
        logic debug_on;
        logic saf_on;
        logic bb_on;
        logic [16:0] bb_words;
        logic [4:0] wp_mask;
        logic prio_once;
        logic ivt_once;
        logic pps_once;
        logic clkout_on;
    } cwo_opts_s;

    function automatic logic [7:0] cwo_word_mask(input logic [2:0] idx);
        case (idx)
            3'h0: cwo_word_mask = MASK_CLOCK_LOCK;
            3'h1: cwo_word_mask = MASK_RESET_POWER;
            3'h2: cwo_word_mask = MASK_SYSTEM;
            3'h3: cwo_word_mask = MASK_WDT_MODE_PERIOD;
            3'h4: cwo_word_mask = MASK_WDT_CLOCK_WINDOW;
            3'h5: cwo_word_mask = MASK_MEM_PARTITION;
            3'h6: cwo_word_mask = MASK_WRITE_PROTECT;
            default: cwo_word_mask = 8'h00;
        endcase
    endfunction : cwo_word_mask
endpackage : cwo_pkg

/* rtl/cwo_lock_ctl.sv */
`timescale 1ns/1ps
module cwo_lock_ctl
    import cwo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic once_i,
    input wire logic unlocked_i,
    input wire logic set_req_i,
    input wire logic clr_req_i,
    output logic locked_o
);
    // ****************************************************************
    // One-way lock flag
    // ****************************************************************
    typedef struct packed {
        cwo_lock_e st;
    } cwo_lk_s;

    cwo_lk_s q;
    cwo_lk_s next_q;

    always_comb begin
        next_q = q;
        case (q.st)
            CWO_LOCK_OPEN: begin
                if (set_req_i && unlocked_i) begin
                    next_q.st = CWO_LOCK_SET;
                end
            end
            CWO_LOCK_SET: begin
                if (clr_req_i && unlocked_i) begin
                    next_q.st = once_i ? CWO_LOCK_CLEARED : CWO_LOCK_OPEN;
                end
            end
            CWO_LOCK_CLEARED: begin
                // Second set after a clear freezes the flag until reset.
                if (set_req_i && unlocked_i) begin
                    next_q.st = once_i ? CWO_LOCK_FROZEN : CWO_LOCK_SET;
                end
            end
            CWO_LOCK_FROZEN: begin
                next_q.st = CWO_LOCK_FROZEN;
            end
            default: begin
                next_q.st = CWO_LOCK_OPEN;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.st <= CWO_LOCK_OPEN;
        end else begin
            q <= next_q;
        end
    end

    assign locked_o = (q.st == CWO_LOCK_SET) || (q.st == CWO_LOCK_FROZEN);
endmodule : cwo_lock_ctl

/* rtl/cwo_clk_div.sv */
`timescale 1ns/1ps
module cwo_clk_div
    import cwo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic clk_o
);
    // ****************************************************************
    // Fosc/4 output toggle
    // ****************************************************************
    typedef struct packed {
        logic [15:0] cnt;
        logic lvl;
    } cwo_div_s;

    cwo_div_s q;
    cwo_div_s next_q;

    always_comb begin
        next_q = q;
        if (!run_i) begin
            next_q.cnt = 16'h0000;
            next_q.lvl = 1'b0;
        end else if (q.cnt == FOSC4_DIV - 16'h0001) begin
            next_q.cnt = 16'h0000;
            next_q.lvl = !q.lvl;
        end else begin
            next_q.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign clk_o = q.lvl;
endmodule : cwo_clk_div

/* rtl/cwo_config_decode.sv */
`timescale 1ns/1ps
// Behaviour
// - Priority lock once-only when option is one.
// - Clock out ignored in crystal modes.
// - Decode two-bit brown-out enable, low-power bit.
// - Vector table lock once-only when option set.
// - Multivector bit selects vectored or legacy interrupts.
// - Power-up timer select: off, 64, 16, 1 ms.
// - Low-voltage programming forces master clear pin.
// - Refuse clearing low-voltage enable over that interface.
// - Extended instruction bit one means legacy mode.
// - Stack fault reset enable bit.
// - Pin-select lock settable once when option set.
// - Zero-cross detector forced on when bit zero.
// - Brown-out threshold from two-bit field.
// - Watchdog mode field decode.
// - Watchdog prescaler loaded from period field.
// - Watchdog clock source selection.
// - Watchdog window and keyed access selection.
// - Debugger enabled when bit is zero.
// - Storage flash and boot block active-low enables.
// - Boot block size doubles, clamped to half.
// - Boot size changes only while block disabled.
// - Active-low write protects, erased only by bulk erase or reset.
module cwo_config_decode
    import cwo_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input cwo_prog_s PROG_I,
    input wire logic [2:0] EXT_OSC_MODE_I,
    input wire logic LOAD_I,
    input wire logic PRIO_UNLOCKED_I,
    input wire logic PRIO_SET_I,
    input wire logic PRIO_CLR_I,
    input wire logic IVT_UNLOCKED_I,
    input wire logic IVT_SET_I,
    input wire logic IVT_CLR_I,
    input wire logic PPS_UNLOCKED_I,
    input wire logic PPS_SET_I,
    input wire logic PPS_CLR_I,
    input wire logic SOFT_BOR_I,
    input wire logic SLEEP_I,
    input wire logic WDT_SOFT_EN_I,
    output logic [7:0] PROG_RDATA_O,
    output logic PROG_REFUSED_O,
    output cwo_opts_s OPTS_O,
    output logic BOR_ACTIVE_O,
    output logic WDT_ACTIVE_O,
    output logic PRIO_LOCKED_O,
    output logic IVT_LOCKED_O,
    output logic PPS_LOCKED_O,
    output logic CLK_OUT_O,
    output logic CLK_OUT_ON_O
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [NUM_WORDS-1:0][7:0] nvm;
        cwo_opts_s opts;
        logic [7:0] rdata;
        logic refused;
    } cwo_top_s;

    cwo_top_s q;
    cwo_top_s next_q;
    logic [2:0] widx;
    logic hit;
    logic [7:0] mask;
    logic [7:0] wdat;
    logic [7:0] w_lock;
    logic [7:0] w_rp;
    logic [7:0] w_sys;
    logic [7:0] w_wmp;
    logic [7:0] w_wcw;
    logic [7:0] w_mp;
    logic [7:0] w_wp;
    logic crystal;
    logic [16:0] bb_calc;

    always_comb begin
        hit = 1'b1;
        widx = 3'h0;
        case (PROG_I.addr)
            ADDR_CLOCK_LOCK: widx = 3'h0;
            ADDR_RESET_POWER: widx = 3'h1;
            ADDR_SYSTEM: widx = 3'h2;
            ADDR_WDT_MODE_PERIOD: widx = 3'h3;
            ADDR_WDT_CLOCK_WINDOW: widx = 3'h4;
            ADDR_MEM_PARTITION: widx = 3'h5;
            ADDR_WRITE_PROTECT: widx = 3'h6;
            default: hit = 1'b0;
        endcase
    end

    assign mask = cwo_word_mask(widx);
    assign w_lock = q.nvm[0];
    assign w_rp = q.nvm[1];
    assign w_sys = q.nvm[2];
    assign w_wmp = q.nvm[3];
    assign w_wcw = q.nvm[4];
    assign w_mp = q.nvm[5];
    assign w_wp = q.nvm[6];

    // ****************************************************************
    // Programming writes and option decode
    // ****************************************************************
    always_comb begin
        next_q = q;
        next_q.refused = 1'b0;
        // Bits outside the writable mask keep old values; programming only clears bits, except that low-voltage writes force the low-voltage enable to one.
        wdat = q.nvm[widx] & (PROG_I.data | ~mask);
        if (PROG_I.lv_mode && (widx == 3'h2) && !PROG_I.data[POS_LV_PROG]) begin
            wdat[POS_LV_PROG] = 1'b1;
        end
        if (!w_mp[POS_BB_N] && (widx == 3'h5)) begin
            wdat[POS_BB_SIZE +: 3] = w_mp[POS_BB_SIZE +: 3];
            wdat[POS_BB_N] = 1'b0;
        end
        if (PROG_I.bulk_erase) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                next_q.nvm[i] = ERASED_WORD & cwo_word_mask(3'(i));
            end
        end else if (PROG_I.wr && hit) begin
            // Cleared protect bits survive until bulk erase or reset.
            next_q.nvm[widx] = wdat;
            next_q.refused = (wdat != (PROG_I.data & mask));
        end
        if (PROG_I.rd && hit) begin
            next_q.rdata = q.nvm[widx];
        end
        if (LOAD_I) begin
            next_q.opts.prio_once = w_lock[POS_PRIO_ONCE];
            next_q.opts.ivt_once = w_rp[POS_IVT_ONCE];
            next_q.opts.pps_once = w_sys[POS_PPS_ONCE];
            next_q.opts.clkout_on = !w_lock[POS_CLKOUT_N];
            next_q.opts.bor_mode = cwo_mode_e'(w_rp[POS_BOR_EN +: 2]);
            next_q.opts.lp_bor_on = !w_rp[POS_LP_BOR_N];
            next_q.opts.mvec_on = w_rp[POS_MVEC];
            next_q.opts.pwrt_sel = w_rp[POS_PWRT +: 2];
            case (w_rp[POS_PWRT +: 2])
                2'h2: next_q.opts.pwrt_cycles = 32'(PWRT_64MS * CYC_PER_MS);
                2'h1: next_q.opts.pwrt_cycles = 32'(PWRT_16MS * CYC_PER_MS);
                2'h0: next_q.opts.pwrt_cycles = 32'(PWRT_1MS * CYC_PER_MS);
                default: next_q.opts.pwrt_cycles = 32'h00000000;
            endcase
            next_q.opts.mclr_on = w_sys[POS_LV_PROG] || w_rp[POS_MCLR_EN];
            next_q.opts.xisa_on = !w_sys[POS_XISA_DIS];
            next_q.opts.stack_reset_on = w_sys[POS_STACK_RST];
            next_q.opts.zc_forced_on = !w_sys[POS_ZC_DIS];
            next_q.opts.zc_soft_ok = w_sys[POS_ZC_DIS];
            next_q.opts.bor_level = w_sys[POS_BOR_V +: 2];
            next_q.opts.wdt_mode = cwo_mode_e'(w_wmp[POS_WDT_MODE +: 2]);
            // Only the all-ones code hands the prescaler to software.
            if (w_wmp[POS_WDT_PER +: 5] == WDT_PER_SOFT) begin
                next_q.opts.wdt_prescale = WDT_PER_SOFT_LOAD;
                next_q.opts.wdt_prescale_soft = 1'b1;
            end else begin
                next_q.opts.wdt_prescale = w_wmp[POS_WDT_PER +: 5];
                next_q.opts.wdt_prescale_soft = 1'b0;
            end
            next_q.opts.wdt_clock = w_wcw[POS_WDT_CLK +: 3];
            next_q.opts.wdt_clock_soft = (w_wmp[POS_WDT_MODE +: 2] != 2'h0)
                && (w_wcw[POS_WDT_CLK +: 3] == WDT_CLK_SOFT);
            next_q.opts.wdt_window = w_wcw[POS_WDT_WIN +: 3];
            next_q.opts.wdt_window_soft = w_wcw[POS_WDT_WIN +: 3] >= WDT_WIN_SOFT_MIN;
            next_q.opts.wdt_keyed = w_wcw[POS_WDT_WIN +: 3] < WDT_WIN_SOFT_MIN;
            next_q.opts.debug_on = !w_mp[POS_DEBUG_N];
            next_q.opts.saf_on = !w_mp[POS_SAF_N];
            next_q.opts.bb_on = !w_mp[POS_BB_N];
            next_q.opts.bb_words = w_mp[POS_BB_N] ? 17'h00000 : bb_calc;
            next_q.opts.wp_mask = {!w_wp[POS_WP_APP],
                !w_wp[POS_WP_SAF] && !w_mp[POS_SAF_N],
                !w_wp[POS_WP_EE],
                !w_wp[POS_WP_CFG],
                !w_wp[POS_WP_BOOT] && !w_mp[POS_BB_N]};
        end
    end

    // Size doubles per step below the smallest code; reserved code is clamped too.
    always_comb begin
        bb_calc = 17'(BB_SMALLEST_WORDS) << (BB_SIZE_SMALLEST - w_mp[POS_BB_SIZE +: 3]);
        if ((w_mp[POS_BB_SIZE +: 3] == BB_SIZE_RESERVED) || (bb_calc > 17'(PFM_WORDS / 2))) begin
            bb_calc = 17'(PFM_WORDS / 2);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                q.nvm[i] <= ERASED_WORD & cwo_word_mask(3'(i));
            end
            q.nvm[1] <= RESET_POWER_RESET;
            q.opts <= '0;
            q.rdata <= 8'h00;
            q.refused <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // Live option effects
    // ****************************************************************
    assign crystal = (EXT_OSC_MODE_I == XOSC_HS) || (EXT_OSC_MODE_I == XOSC_XT)
        || (EXT_OSC_MODE_I == XOSC_LP);
    assign CLK_OUT_ON_O = q.opts.clkout_on && !crystal;

    cwo_clk_div u_div (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .run_i(CLK_OUT_ON_O),
        .clk_o(CLK_OUT_O)
    );

    always_comb begin
        case (q.opts.bor_mode)
            CWO_BOR_ALWAYS: BOR_ACTIVE_O = 1'b1;
            CWO_BOR_AWAKE: BOR_ACTIVE_O = !SLEEP_I;
            CWO_BOR_SOFT: BOR_ACTIVE_O = SOFT_BOR_I;
            default: BOR_ACTIVE_O = 1'b0;
        endcase
        case (q.opts.wdt_mode)
            CWO_BOR_ALWAYS: WDT_ACTIVE_O = 1'b1;
            CWO_BOR_AWAKE: WDT_ACTIVE_O = !SLEEP_I;
            CWO_BOR_SOFT: WDT_ACTIVE_O = WDT_SOFT_EN_I;
            default: WDT_ACTIVE_O = 1'b0;
        endcase
    end

    cwo_lock_ctl u_prio (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .once_i(q.opts.prio_once),
        .unlocked_i(PRIO_UNLOCKED_I),
        .set_req_i(PRIO_SET_I),
        .clr_req_i(PRIO_CLR_I),
        .locked_o(PRIO_LOCKED_O)
    );

    cwo_lock_ctl u_ivt (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .once_i(q.opts.ivt_once),
        .unlocked_i(IVT_UNLOCKED_I),
        .set_req_i(IVT_SET_I),
        .clr_req_i(IVT_CLR_I),
        .locked_o(IVT_LOCKED_O)
    );

    // With the once option set, pin-select clears are masked, so a single set already freezes it.
    cwo_lock_ctl u_pps (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .once_i(q.opts.pps_once),
        .unlocked_i(PPS_UNLOCKED_I),
        .set_req_i(PPS_SET_I),
        .clr_req_i(PPS_CLR_I & ~q.opts.pps_once),
        .locked_o(PPS_LOCKED_O)
    );

    assign OPTS_O = q.opts;
    assign PROG_RDATA_O = q.rdata;
    assign PROG_REFUSED_O = q.refused;
endmodule : cwo_config_decode

/* sim/cwo_config_decode_properties.sv */
`timescale 1ns/1ps
// ********
// Port checker
// ********
module cwo_config_decode_properties
    import cwo_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input cwo_prog_s PROG_I,
    input wire logic [2:0] EXT_OSC_MODE_I,
    input wire logic LOAD_I,
    input wire logic PRIO_UNLOCKED_I,
    input wire logic PRIO_SET_I,
    input wire logic PRIO_CLR_I,
    input wire logic SOFT_BOR_I,
    input wire logic SLEEP_I,
    input wire logic WDT_SOFT_EN_I,
    input wire logic PROG_REFUSED_O,
    input cwo_opts_s OPTS_O,
    input wire logic BOR_ACTIVE_O,
    input wire logic WDT_ACTIVE_O,
    input wire logic PRIO_LOCKED_O,
    input wire logic CLK_OUT_O,
    input wire logic CLK_OUT_ON_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    bor_follow_a: assert property (
        BOR_ACTIVE_O == ((OPTS_O.bor_mode == CWO_BOR_ALWAYS) || (OPTS_O.bor_mode ==
        CWO_BOR_AWAKE && !SLEEP_I) || (OPTS_O.bor_mode == CWO_BOR_SOFT && SOFT_BOR_I)))
        else $error("brown-out activity wrong");
    wdt_follow_a: assert property (
        WDT_ACTIVE_O == ((OPTS_O.wdt_mode == CWO_BOR_ALWAYS) || (OPTS_O.wdt_mode ==
        CWO_BOR_AWAKE && !SLEEP_I) || (OPTS_O.wdt_mode == CWO_BOR_SOFT && WDT_SOFT_EN_I)))
        else $error("watchdog activity wrong");
    clkout_pin_a: assert property (
        CLK_OUT_ON_O == (OPTS_O.clkout_on && (EXT_OSC_MODE_I > XOSC_HS)))
        else $error("clock out pin function wrong");
    clkout_rate_a: assert property (
        $rose(CLK_OUT_O) && CLK_OUT_ON_O && $past(CLK_OUT_ON_O, 3) |=>
        (CLK_OUT_O || !CLK_OUT_ON_O) ##1 (!CLK_OUT_O || !CLK_OUT_ON_O))
        else $error("clock out half period wrong");
    opts_hold_a: assert property (!$past(LOAD_I) |-> $stable(OPTS_O))
        else $error("options changed without load");
    prio_set_a: assert property (
        $rose(PRIO_LOCKED_O) |-> $past(PRIO_SET_I && PRIO_UNLOCKED_I))
        else $error("priority lock set without request");
    prio_clr_a: assert property (
        $fell(PRIO_LOCKED_O) |-> $past(PRIO_CLR_I && PRIO_UNLOCKED_I && !OPTS_O.prio_once)
        || $past(PRIO_CLR_I && PRIO_UNLOCKED_I) && OPTS_O.prio_once)
        else $error("priority lock cleared without request");
    refuse_cause_a: assert property (PROG_REFUSED_O |-> $past(PROG_I.wr))
        else $error("refusal without write");
endmodule : cwo_config_decode_properties

bind cwo_config_decode cwo_config_decode_properties chk_u (.REF_CLK_I(REF_CLK_I),
    .RST_N_I(RST_N_I), .PROG_I(PROG_I), .EXT_OSC_MODE_I(EXT_OSC_MODE_I), .LOAD_I(LOAD_I),
    .PRIO_UNLOCKED_I(PRIO_UNLOCKED_I), .PRIO_SET_I(PRIO_SET_I), .PRIO_CLR_I(PRIO_CLR_I),
    .SOFT_BOR_I(SOFT_BOR_I), .SLEEP_I(SLEEP_I), .WDT_SOFT_EN_I(WDT_SOFT_EN_I),
    .PROG_REFUSED_O(PROG_REFUSED_O), .OPTS_O(OPTS_O), .BOR_ACTIVE_O(BOR_ACTIVE_O),
    .WDT_ACTIVE_O(WDT_ACTIVE_O), .PRIO_LOCKED_O(PRIO_LOCKED_O), .CLK_OUT_O(CLK_OUT_O),
    .CLK_OUT_ON_O(CLK_OUT_ON_O));

/* sim/cwo_programmer.sv */
`timescale 1ns/1ps
// ********
// Programmer model
// ********
module cwo_programmer
    import cwo_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic refused_i,
    output cwo_prog_s prog_o
);
    initial prog_o = '0;
    // Released address and data are inverted so a stale value never looks valid.
    task automatic issue(input logic [2:0] op, input logic [21:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic f);
        @(posedge clk_i);
        #1;
        {prog_o.wr, prog_o.rd, prog_o.bulk_erase} = op;
        prog_o.addr = a;
        prog_o.data = d;
        @(posedge clk_i);
        #1;
        q = rdata_i;
        f = refused_i;
        {prog_o.wr, prog_o.rd, prog_o.bulk_erase} = 3'h0;
        prog_o.addr = ~a;
        prog_o.data = ~d;
    endtask : issue
    // The enable is only cleared after leaving the low-voltage path.
    task automatic set_lv(input logic lv);
        prog_o.lv_mode = lv;
    endtask : set_lv
endmodule : cwo_programmer

/* sim/tb.sv */
`timescale 1ns/1ps
// ********
// Bench top
// ********
module tb;
    import cwo_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic load = 1'b0;
    logic soft_bor = 1'b0;
    logic sleep = 1'b0;
    logic [2:0] osc = 3'h7;
    logic [2:0] unl = 3'h0;
    logic [2:0] setq = 3'h0;
    logic [2:0] clrq = 3'h0;
    logic [2:0] locked;
    logic [7:0] rdata, q;
    logic refused, bor_act, wdt_act, osc_clk, osc_is, f;
    logic [3:0] v;
    cwo_prog_s prog;
    cwo_opts_s opts;
    int miscompares = 0;
    int n_checks = 0;
    logic [7:0] erased [7] = '{8'h2B, 8'hFF, 8'hBF, 8'h7F, 8'h3F, 8'h3F, 8'h8F};
    always #10 clk = ~clk;
    cwo_programmer prog_u (.clk_i(clk), .rdata_i(rdata), .refused_i(refused), .prog_o(prog));
    cwo_config_decode dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .PROG_I(prog),
        .EXT_OSC_MODE_I(osc), .LOAD_I(load), .PRIO_UNLOCKED_I(unl[0]), .PRIO_SET_I(setq[0]),
        .PRIO_CLR_I(clrq[0]), .IVT_UNLOCKED_I(unl[1]), .IVT_SET_I(setq[1]),
        .IVT_CLR_I(clrq[1]), .PPS_UNLOCKED_I(unl[2]), .PPS_SET_I(setq[2]),
        .PPS_CLR_I(clrq[2]), .SOFT_BOR_I(soft_bor), .SLEEP_I(sleep), .WDT_SOFT_EN_I(~sleep),
        .PROG_RDATA_O(rdata), .PROG_REFUSED_O(refused), .OPTS_O(opts),
        .BOR_ACTIVE_O(bor_act), .WDT_ACTIVE_O(wdt_act), .PRIO_LOCKED_O(locked[0]),
        .IVT_LOCKED_O(locked[1]), .PPS_LOCKED_O(locked[2]), .CLK_OUT_O(osc_clk),
        .CLK_OUT_ON_O(osc_is));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [21:0] a, input logic [7:0] d, input logic r);
        prog_u.issue(3'h4, a, d, q, f);
        check("refused", f, r);
    endtask : wr
    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        prog_u.issue(3'h2, a, 8'h00, q, f);
        check("rdata", q, e);
    endtask : rd
    task automatic pulse_load();
        @(posedge clk);
        #1;
        load = 1'b1;
        @(posedge clk);
        #1;
        load = 1'b0;
    endtask : pulse_load
    task automatic lock_op(input int k, input logic s, input logic u, input logic e);
        @(posedge clk);
        #1;
        unl[k] = u;
        setq[k] = s;
        clrq[k] = ~s;
        @(posedge clk);
        #1;
        setq[k] = 1'b0;
        clrq[k] = 1'b0;
        check("locked", locked[k], e);
    endtask : lock_op
    // Cuts a hang short; a run needs well under a thousand cycles.
    initial begin
        #1000000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ADDR_CLOCK_LOCK + 22'(i), (i == 1) ? RESET_POWER_RESET : erased[i]);
        end
        wr(22'h300008, 8'h00, 1'b0);
        rd(22'h300000, 8'h8F);
        prog_u.set_lv(1'b1);
        wr(ADDR_SYSTEM, 8'h00, 1'b1);
        rd(ADDR_SYSTEM, 8'h20);
        prog_u.set_lv(1'b0);
        wr(ADDR_SYSTEM, 8'h00, 1'b0);
        wr(ADDR_SYSTEM, 8'hBF, 1'b1);
        wr(ADDR_MEM_PARTITION, 8'h17, 1'b0);
        wr(ADDR_MEM_PARTITION, 8'h10, 1'b1);
        rd(ADDR_MEM_PARTITION, 8'h17);
        wr(ADDR_CLOCK_LOCK, 8'h2A, 1'b0);
        wr(ADDR_RESET_POWER, 8'h5C, 1'b0);
        wr(ADDR_WDT_MODE_PERIOD, 8'h52, 1'b0);
        wr(ADDR_WDT_CLOCK_WINDOW, 8'h15, 1'b0);
        wr(ADDR_WRITE_PROTECT, 8'h00, 1'b0);
        wr(ADDR_WRITE_PROTECT, 8'h8F, 1'b1);
        $display("test programming done");
        pulse_load();
        check("bb_words", opts.bb_words, 17'(BB_SMALLEST_WORDS));
        check("debug_saf", {opts.debug_on, opts.saf_on, opts.bb_on}, 3'h5);
        check("bor", {opts.bor_mode, opts.lp_bor_on, opts.bor_level}, 5'hC);
        check("pwrt", {opts.mvec_on, opts.pwrt_sel}, 3'h6);
        check("pwrt_cyc", opts.pwrt_cycles, 32'(PWRT_64MS * CYC_PER_MS));
        check("sys", {opts.mclr_on, opts.xisa_on, opts.stack_reset_on}, 3'h2);
        check("zc_wp", {opts.zc_forced_on, opts.wp_mask}, 6'h37);
        check("wdt_mode", opts.wdt_mode, CWO_BOR_AWAKE);
        check("wdt_per", {opts.wdt_prescale, opts.wdt_prescale_soft}, 6'h24);
        check("wdt_clk", {opts.wdt_clock, opts.wdt_clock_soft}, 4'h4);
        check("wdt_win", {opts.wdt_window, opts.wdt_window_soft, opts.wdt_keyed}, 5'h15);
        soft_bor = 1'b1;
        sleep = 1'b1;
        #1;
        check("act", {bor_act, wdt_act}, 2'h2);
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            #1;
            osc = 3'(m);
            soft_bor = 1'b0;
            sleep = 1'b0;
            #1;
            check("osc_is", osc_is, 1'(m > 2));
        end
        for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            #1;
            v[j] = osc_clk;
        end
        check("osc_rate", {v[2], v[3]}, {~v[0], ~v[1]});
        for (int k = 0; k < 3; k++) begin
            lock_op(k, 1'b1, 1'b0, 1'b0);
            lock_op(k, 1'b1, 1'b1, 1'b1);
            lock_op(k, 1'b0, 1'b1, 1'b0);
            lock_op(k, 1'b1, 1'b1, 1'b1);
            lock_op(k, 1'b0, 1'b1, (k == 2) ? 1'b0 : 1'b1);
        end
        $display("test decode done");
        prog_u.issue(3'h1, ADDR_CLOCK_LOCK, 8'h00, q, f);
        for (int i = 0; i < 7; i++) begin
            rd(ADDR_CLOCK_LOCK + 22'(i), erased[i]);
        end
        check("held", opts.pwrt_sel, 2'h2);
        wr(ADDR_RESET_POWER, 8'hFE, 1'b0);
        pulse_load();
        sleep = 1'b1;
        #1;
        check("act", {bor_act, wdt_act}, 2'h3);
        check("wdt_per", {opts.wdt_prescale, opts.wdt_prescale_soft}, 6'h17);
        check("wdt_soft", {opts.wdt_clock_soft, opts.wdt_window_soft, opts.wdt_keyed}, 3'h6);
        check("sys", {opts.mclr_on, opts.xisa_on, opts.stack_reset_on}, 3'h5);
        check("misc", {opts.zc_forced_on, opts.debug_on, opts.bb_on}, 3'h0);
        lock_op(2, 1'b1, 1'b1, 1'b1);
        lock_op(2, 1'b0, 1'b1, 1'b1);
        $display("test erase done");
        test_done();
    end
endmodule : tb
